//--- src/crx_pkg.sv
// constants and types for the call/return/reset execution block
// assumes a 21-bit program counter and one 100 MHz system clock
//
// Overview of operation
// - relative call pushes call address plus 2, loads target, second cycle idle
// - call target is incremented pc plus two times signed offset field
// - software reset opcode 0x00FF performs the master-clear reset
// - software reset is one cycle, reset starts in Q2, Q3/Q4 idle
// - return from interrupt pops stack into pc in Q4 of first cycle
// - return from interrupt sets high or low priority global enable only
// - shadow flag 1 restores working, status and bank select from shadows
// - shadow flag 0 leaves working, status and bank select unchanged
// - return with literal loads working register with literal, pc from stack top
// - return with literal: literal read Q2, pop and write Q4, cycle 2 idle
// - stack-reloading returns leave pc upper and high latches untouched
package crx_pkg;
   // ==========================================================
   // widths
   localparam int PC_W   = 21;
   localparam int DATA_W = 8;
   localparam int BANK_W = 6;
   localparam int OFS_W  = 11;
   // ==========================================================
   // opcodes, reset values and pc step
   localparam logic [15:0] OP_SWRESET  = 16'h00FF;
   localparam logic [14:0] OP_RET_INT  = 15'h0008;
   localparam logic [7:0]  OP_RET_LIT  = 8'h0C;
   localparam logic [4:0]  OP_REL_CALL = 5'h1B;
   localparam logic [DATA_W-1:0] W_RST    = 8'h00;
   localparam logic [DATA_W-1:0] ST_RST   = 8'h00;
   localparam logic [BANK_W-1:0] BANK_RST = 6'h00;
   localparam logic [PC_W-1:0]   PC_RST  = 21'h000000;
   localparam logic [PC_W-1:0]   PC_STEP = 21'h000002;
   // ==========================================================
   // types
   typedef enum logic [1:0] {CRX_Q1, CRX_Q2, CRX_Q3, CRX_Q4} crx_q_t;
   typedef enum logic [2:0] {CRX_NONE, CRX_CALL, CRX_SWRST, CRX_RETI, CRX_RETL}
      crx_op_t;
endpackage

//--- src/crx_ctl_if.sv
// decoded instruction between the decoder and the sequencer
// assumes both ends share the system clock
interface crx_ctl_if;
   import crx_pkg::*;
   crx_op_t             op;
   logic                shadow;
   logic [DATA_W-1:0]   literal;
   logic [PC_W-1:0]     target;
   modport dec (output op, output shadow, output literal, output target);
   modport seq (input op, input shadow, input literal, input target);
endinterface

//--- src/crx_decode.sv
// opcode decoder and relative call target arithmetic
// assumes pc is the address of the instruction being decoded
module crx_decode
   import crx_pkg::*;
(
   input  wire logic [15:0]    i_instr,
   input  wire logic [PC_W-1:0] i_pc,
   crx_ctl_if.dec              ctl
);
   logic [PC_W-1:0] ofs2;
   always_comb
   begin
      ctl.op = CRX_NONE;
      if (i_instr[15:11] == OP_REL_CALL)
         ctl.op = CRX_CALL;
      else if (i_instr == OP_SWRESET)
         ctl.op = CRX_SWRST;
      else if (i_instr[15:1] == OP_RET_INT)
         ctl.op = CRX_RETI;
      else if (i_instr[15:8] == OP_RET_LIT)
         ctl.op = CRX_RETL;
   end
   assign ctl.shadow  = i_instr[0];
   assign ctl.literal = i_instr[7:0];
   // sign-extended offset doubled
   assign ofs2 = {{(PC_W-OFS_W-1){i_instr[10]}}, i_instr[10:0], 1'b0};
   assign ctl.target = i_pc + PC_STEP + ofs2;
endmodule

//--- src/crx_exec.sv
// call/return/reset execution sequencer
// assumes an instruction word presented for a whole cycle from Q1
module crx_exec
   import crx_pkg::*;
(
   // clock and reset
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_nrst,
   // instruction stream
   input  wire logic                  i_valid,
   input  wire logic [15:0]           i_instr,
   input  wire logic [PC_W-1:0]       i_pc,
   input  wire logic                  i_interrupt_priority_high,
   // return stack
   input  wire logic [PC_W-1:0]       i_stack_top,
   output logic                       o_push,
   output logic [PC_W-1:0]            o_push_data,
   output logic                       o_pop,
   // core registers
   input  wire logic [DATA_W-1:0]     i_working_shadow,
   input  wire logic [DATA_W-1:0]     i_status_shadow,
   input  wire logic [BANK_W-1:0]     i_bank_select_shadow,
   output logic [PC_W-1:0]            o_pc,
   output logic [DATA_W-1:0]          o_working,
   output logic [DATA_W-1:0]          o_status,
   output logic [BANK_W-1:0]          o_bank_select_register,
   output logic [7:0]                 o_pc_high_latch,
   output logic [7:0]                 o_pc_upper_latch,
   output logic                       o_high_priority_global_enable,
   output logic                       o_low_priority_global_enable,
   // status
   output crx_pkg::crx_q_t            o_phase,
   output logic                       o_busy,
   output logic                       o_soft_reset
);
   import crx_pkg::*;
   // ==========================================================
   // reset synchroniser
   logic rs1_reg, rs2_reg, swr_reg, swr_next, rst_n;
   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rs1_reg <= 1'b0;
         rs2_reg <= 1'b0;
      end
      else
      begin
         rs1_reg <= 1'b1;
         rs2_reg <= rs1_reg;
      end
   end
   // software reset acts as the master clear for every register of the block except the reset synchroniser and swr_reg
   assign rst_n = rs2_reg & ~swr_reg;
   // ==========================================================
   // decoder
   crx_ctl_if ctl ();
   crx_decode u_dec
   (
      .i_instr (i_instr),
      .i_pc    (i_pc),
      .ctl     (ctl)
   );
   // ==========================================================
   // state
   crx_q_t            q_reg, q_next;
   crx_op_t           op_reg, op_next;
   logic              idle2_reg, idle2_next;
   logic              sh_reg, sh_next;
   logic [DATA_W-1:0] lit_reg, lit_next;
   logic [PC_W-1:0]   tgt_reg, tgt_next, pc_reg, pc_next;
   logic [DATA_W-1:0] w_reg, w_next, st_reg, st_next;
   logic [BANK_W-1:0] bank_reg, bank_next;
   logic              gh_reg, gh_next, gl_reg, gl_next;
   logic              push_next, pop_next, push_reg, pop_reg;
   logic [PC_W-1:0]   pd_reg, pd_next;
   always_comb
   begin
      q_next     = crx_q_t'(q_reg + 2'd1);
      op_next    = op_reg;
      idle2_next = idle2_reg;
      sh_next    = sh_reg;
      lit_next   = lit_reg;
      tgt_next   = tgt_reg;
      pc_next    = pc_reg;
      w_next     = w_reg;
      st_next    = st_reg;
      bank_next  = bank_reg;
      gh_next    = gh_reg;
      gl_next    = gl_reg;
      push_next  = 1'b0;
      pop_next   = 1'b0;
      pd_next    = pd_reg;
      swr_next   = 1'b0;
      case (q_reg)
         CRX_Q1:
         begin
            if (idle2_reg)
               op_next = CRX_NONE;
            else if (i_valid)
            begin
               op_next  = ctl.op;
               sh_next  = ctl.shadow;
               tgt_next = ctl.target;
            end
            else
               op_next = CRX_NONE;
         end
         CRX_Q2:
         begin
            case (op_reg)
               CRX_CALL:
               begin
                  push_next = 1'b1;
                  pd_next   = i_pc + PC_STEP;
               end
               CRX_SWRST: swr_next = 1'b1;
               CRX_RETL:  lit_next = ctl.literal;
               default:   lit_next = lit_reg;
            endcase
         end
         CRX_Q3: op_next = op_reg;
         CRX_Q4:
         begin
            idle2_next = 1'b0;
            case (op_reg)
               CRX_CALL:
               begin
                  pc_next    = tgt_reg;
                  idle2_next = 1'b1;
               end
               CRX_RETI:
               begin
                  pop_next   = 1'b1;
                  pc_next    = i_stack_top;
                  idle2_next = 1'b1;
                  if (i_interrupt_priority_high)
                     gh_next = 1'b1;
                  else
                     gl_next = 1'b1;
                  if (sh_reg)
                  begin
                     w_next   = i_working_shadow;
                     st_next  = i_status_shadow;
                     bank_next = i_bank_select_shadow;
                  end                                              // else kept
               end
               CRX_RETL:
               begin
                  pop_next   = 1'b1;
                  pc_next    = i_stack_top;
                  w_next     = lit_reg;
                  idle2_next = 1'b1;
               end
               default: pc_next = pc_reg;
            endcase
         end
         default: q_next = CRX_Q1;
      endcase
   end
   always_ff @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q_reg     <= CRX_Q1;
         op_reg    <= CRX_NONE;
         idle2_reg <= 1'b0;
         sh_reg    <= 1'b0;
         lit_reg   <= W_RST;
         tgt_reg   <= PC_RST;
         pc_reg    <= PC_RST;
         w_reg     <= W_RST;
         st_reg    <= ST_RST;
         bank_reg  <= BANK_RST;
         gh_reg    <= 1'b0;
         gl_reg    <= 1'b0;
         push_reg  <= 1'b0;
         pop_reg   <= 1'b0;
         pd_reg    <= PC_RST;
      end
      else
      begin
         q_reg     <= q_next;
         op_reg    <= op_next;
         idle2_reg <= idle2_next;
         sh_reg    <= sh_next;
         lit_reg   <= lit_next;
         tgt_reg   <= tgt_next;
         pc_reg    <= pc_next;
         w_reg     <= w_next;
         st_reg    <= st_next;
         bank_reg  <= bank_next;
         gh_reg    <= gh_next;
         gl_reg    <= gl_next;
         push_reg  <= push_next;
         pop_reg   <= pop_next;
         pd_reg    <= pd_next;
      end
   end
   // pulse lives on the synchronised reset only, else it would clear itself
   always_ff @(posedge i_clk_sys or negedge rs2_reg)
   begin
      if (!rs2_reg)
         swr_reg <= 1'b0;
      else
         swr_reg <= swr_next;
   end
   // ==========================================================
   // outputs
   assign o_push                        = push_reg;
   assign o_push_data                   = pd_reg;
   assign o_pop                         = pop_reg;
   assign o_pc                          = pc_reg;
   assign o_working                     = w_reg;
   assign o_status                      = st_reg;
   assign o_bank_select_register        = bank_reg;
   // latches are never written by this block
   assign o_pc_high_latch               = 8'h00;
   assign o_pc_upper_latch              = 8'h00;
   assign o_high_priority_global_enable = gh_reg;
   assign o_low_priority_global_enable  = gl_reg;
   assign o_phase                       = q_reg;
   assign o_busy                        = idle2_reg | (op_reg != CRX_NONE);
   assign o_soft_reset                  = swr_reg;
   // ==========================================================
   // assertions
   // idle second cycle: pop pulse seen first, then three quiet quarters
   sequence s_idle_quarters;
      (!push_reg && !pop_reg && op_reg == CRX_NONE) [*3];
   endsequence
   a_call_push_pc: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (q_reg == CRX_Q2 && op_reg == CRX_CALL) |=> (push_reg && pd_reg == $past(i_pc) + PC_STEP))
      else $error("call push wrong");
   a_call_target: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (q_reg == CRX_Q4 && op_reg == CRX_CALL) |=> (pc_reg == $past(tgt_reg)))
      else $error("call target not loaded");
   a_swreset_q2: assert property (@(posedge i_clk_sys) disable iff (!rs2_reg)
      swr_reg |-> ($past(q_reg) == CRX_Q2 && $past(op_reg) == CRX_SWRST))
      else $error("soft reset at wrong phase");
   a_reti_pop_q4: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      pop_reg |-> ($past(q_reg) == CRX_Q4))
      else $error("pop not in Q4");
   a_reti_enable: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (q_reg == CRX_Q4 && op_reg == CRX_RETI) |=> (gh_reg || gl_reg))
      else $error("no global enable set");
   a_shadow_restore: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (q_reg == CRX_Q4 && op_reg == CRX_RETI && sh_reg)
      |=> (w_reg == $past(i_working_shadow) && bank_reg == $past(i_bank_select_shadow)))
      else $error("shadow not restored");
   a_shadow_keep: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (q_reg == CRX_Q4 && op_reg == CRX_RETI && !sh_reg)
      |=> ($stable(w_reg) && $stable(st_reg) && $stable(bank_reg)))
      else $error("registers changed without shadow");
   a_return_with_literal_load: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (q_reg == CRX_Q4 && op_reg == CRX_RETL)
      |=> (w_reg == $past(lit_reg) && pc_reg == $past(i_stack_top) && pop_reg))
      else $error("return with literal wrong");
   a_second_idle: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      (q_reg == CRX_Q4 && op_reg == CRX_RETL) |=> pop_reg ##1 s_idle_quarters)
      else $error("second cycle not idle");
endmodule

//--- verification/call_return_reset_exec_bench.sv
// self-checking bench for the call/return/reset execution block
// assumes crx_pkg and the design files are compiled before this file
module call_return_reset_exec_bench
   import crx_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // signals
   typedef struct {
      logic              is_push;
      logic              pop;
      int                cyc;
      logic [PC_W-1:0]   pc;
      logic [DATA_W-1:0] w;
      logic [DATA_W-1:0] st;
      logic [BANK_W-1:0] bank;
      logic              hi;
      logic              lo;
   } crx_note_t;
   logic i_clk_sys, i_nrst, i_valid, i_interrupt_priority_high;
   logic [15:0]       i_instr;
   logic [PC_W-1:0]   i_pc, i_stack_top, o_push_data, o_pc, m_pc, pc, last_pc;
   logic [DATA_W-1:0] i_working_shadow, i_status_shadow, o_working, o_status, m_w, m_st;
   logic [BANK_W-1:0] i_bank_select_shadow, o_bank_select_register, m_bank;
   logic [7:0]        o_pc_high_latch, o_pc_upper_latch;
   logic o_push, o_pop, o_soft_reset, o_busy, o_high_priority_global_enable;
   logic o_low_priority_global_enable, m_hi, m_lo, quiet, s;
   logic [10:0]       ofs;
   crx_q_t            o_phase;
   crx_note_t         notes[$];
   int seed, cyc, take, t, mismatches, num_checks;
   crx_exec dut_u (
      .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_valid(i_valid), .i_instr(i_instr),
      .i_pc(i_pc), .i_interrupt_priority_high(i_interrupt_priority_high),
      .i_stack_top(i_stack_top), .o_push(o_push), .o_push_data(o_push_data),
      .o_pop(o_pop), .i_working_shadow(i_working_shadow), .i_status_shadow(i_status_shadow),
      .i_bank_select_shadow(i_bank_select_shadow), .o_pc(o_pc), .o_working(o_working),
      .o_status(o_status), .o_bank_select_register(o_bank_select_register),
      .o_pc_high_latch(o_pc_high_latch), .o_pc_upper_latch(o_pc_upper_latch),
      .o_high_priority_global_enable(o_high_priority_global_enable),
      .o_low_priority_global_enable(o_low_priority_global_enable),
      .o_phase(o_phase), .o_busy(o_busy), .o_soft_reset(o_soft_reset));
   // ==========================================================
   // checking
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic take_note(input logic is_push);
      crx_note_t n;
      if (notes.size() == 0)
      begin
         chk(64'h1, 64'h0);
         return;
      end
      n = notes.pop_front();
      chk(is_push, n.is_push);
      chk(cyc, n.cyc);
      if (is_push)
         chk(o_push_data, n.pc);
      else
      begin
         chk(o_pop, n.pop);
         chk(o_pc, n.pc);
         chk({o_working, o_status, o_bank_select_register}, {n.w, n.st, n.bank});
         chk({o_high_priority_global_enable, o_low_priority_global_enable}, {n.hi, n.lo});
         chk({o_pc_upper_latch, o_pc_high_latch}, 64'h0);
      end
   endtask
   initial
   begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) cyc <= cyc + 1;
   // results are matched in order against the driver's notes
   always @(posedge i_clk_sys)
   begin
      #1;
      if (!quiet && i_nrst)
      begin
         if (o_push !== 1'b0)
            take_note(1'b1);
         if (o_pop !== 1'b0 || o_pc !== last_pc)
            take_note(1'b0);
      end
      last_pc = o_pc;
   end
   // ==========================================================
   // driving
   task automatic edge_wait(input int k);
      repeat (k) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic issue(input logic [15:0] ins, input logic [PC_W-1:0] a);
      t = 0;
      while (o_phase !== CRX_Q1 && t < 8)
      begin
         edge_wait(1);
         t++;
      end
      if (t == 8)
      begin
         chk(64'h1, 64'h0);
         complete_run();
      end
      i_instr = ins;
      i_pc = a;
      i_valid = 1'b1;
      edge_wait(1);
      take = cyc;
      i_valid = 1'b0;
   endtask
   task automatic note(input logic pop);
      notes.push_back('{1'b0, pop, take + 3, m_pc, m_w, m_st, m_bank, m_hi, m_lo});
   endtask
   // literal is gone after Q2, and the idle cycle must refuse a new word
   task automatic finish2();
      edge_wait(1);
      i_instr = {OP_RET_LIT, 8'hA5};
      edge_wait(2);
      chk(o_busy, 1'b1);
      i_valid = 1'b1;
      edge_wait(1);
      i_valid = 1'b0;
   endtask
   initial
   begin
      seed = 25924;
      {mismatches, num_checks, quiet, i_nrst, i_valid} = '0;
      {i_instr, i_pc, i_stack_top, i_interrupt_priority_high} = '0;
      {i_working_shadow, i_status_shadow, i_bank_select_shadow} = '0;
      {m_pc, m_w, m_st, m_bank, m_hi, m_lo} = '0;
      edge_wait(2);
      i_nrst = 1'b1;
      // internal reset lifts two edges after release; earlier words are lost
      edge_wait(2);
      for (int r = 0; r < 12; r++)
      begin
         ofs = (r == 0) ? 11'h400 : (r == 1) ? 11'h3FF : 11'($random(seed));
         if (ofs == 11'h7FF)
            ofs = 11'h001;
         pc = PC_W'($random(seed)) & ~21'h000001;
         issue({OP_REL_CALL, ofs}, pc);
         notes.push_back('{1'b1, 1'b0, take + 1, pc + PC_STEP, m_w, m_st, m_bank, m_hi, m_lo});
         m_pc = pc + PC_STEP + {{9{ofs[10]}}, ofs, 1'b0};
         note(1'b0);
         finish2();
         s = r[0];
         i_interrupt_priority_high = r[1];
         i_working_shadow = DATA_W'($random(seed));
         i_status_shadow = DATA_W'($random(seed));
         i_bank_select_shadow = BANK_W'($random(seed));
         i_stack_top = m_pc ^ PC_W'(($random(seed) << 1) | 2);
         issue({OP_RET_INT, s}, PC_W'($random(seed)));
         m_pc = i_stack_top;
         if (s)
            {m_w, m_st, m_bank} = {i_working_shadow, i_status_shadow, i_bank_select_shadow};
         if (r[1])
            m_hi = 1'b1;
         else
            m_lo = 1'b1;
         note(1'b1);
         finish2();
         // other returns belong elsewhere: must pass as a no-op
         issue(16'h0012 | s, m_pc);
         i_stack_top = m_pc ^ PC_W'(($random(seed) << 1) | 2);
         m_w = DATA_W'($random(seed));
         issue({OP_RET_LIT, m_w}, PC_W'($random(seed)));
         m_pc = i_stack_top;
         note(1'b1);
         finish2();
         if (r == 5)
         begin
            quiet = 1'b1;
            issue(OP_SWRESET, m_pc);
            t = 0;
            while (o_soft_reset !== 1'b1 && t < 4)
            begin
               edge_wait(1);
               t++;
            end
            chk(o_soft_reset, 1'b1);
            edge_wait(6);
            {m_pc, m_w, m_st, m_bank, m_hi, m_lo} = '0;
            chk({o_pc, o_working, o_status, o_bank_select_register}, 64'h0);
            chk({o_high_priority_global_enable, o_low_priority_global_enable}, 64'h0);
            quiet = 1'b0;
         end
      end
      edge_wait(8);
      chk(notes.size(), 64'h0);
      complete_run();
   end
   initial
   begin
      #1000000;
      chk(64'h1, 64'h0);
      complete_run();
   end
endmodule
